//--- hbw_pkg.sv
// Package for the host bus write port: widths, timing counts and carrier types
package hbw_pkg;

  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned CLK_PERIOD_PS = 5000;

  // Host-side timing figures in ns, checked by the port as protocol monitors
  localparam int unsigned T_ASSERT_MIN_NS   = 32;
  localparam int unsigned T_DEASSERT_MIN_NS = 13;
  localparam int unsigned T_CYCLE_MIN_NS    = 165;

  // Least times round up to whole cycles
  localparam int unsigned T_ASSERT_CYC   = (T_ASSERT_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned T_DEASSERT_CYC = (T_DEASSERT_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned T_CYCLE_CYC    = (T_CYCLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX  = 8'hff;
  localparam logic [CNT_W-1:0] ASSERT_LIM   = CNT_W'(T_ASSERT_CYC);
  localparam logic [CNT_W-1:0] DEASSERT_LIM = CNT_W'(T_DEASSERT_CYC);
  localparam logic [CNT_W-1:0] CYCLE_LIM    = CNT_W'(T_CYCLE_CYC);

  localparam int unsigned BUF_DEPTH = 2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } hbw_word_t;

  typedef enum logic {
    HBW_IDLE,
    HBW_ACTIVE
  } hbw_state_t;

endpackage

//--- hbw_write_port.sv
// Host bus write port: strobe framing, capture, routing and two-entry output buffers
`timescale 1ns/1ps

module hbw_write_port
  import hbw_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Host bus pins
  input  wire logic              host_select_n,
  input  wire logic              host_write_strobe_n,
  input  wire logic              fifo_select,
  input  wire logic [ADDR_W-1:0] host_addr,
  input  wire logic [DATA_W-1:0] host_data,
  // Register write stream
  output logic                   reg_wr_valid,
  input  wire logic              reg_wr_ready,
  output hbw_word_t              reg_wr_word,
  // Transmit FIFO stream
  output logic                   txf_wr_valid,
  input  wire logic              txf_wr_ready,
  output logic [DATA_W-1:0]      txf_wr_data,
  // Status
  output logic                   write_dropped,
  output logic                   timing_violation
);

  hbw_state_t       state_q;
  logic             both_low;
  logic             cyc_end;
  logic             cyc_start;
  logic             fifo_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] data_q;
  logic [CNT_W-1:0] low_cnt_q;
  logic [CNT_W-1:0] high_cnt_q;
  logic [CNT_W-1:0] start_cnt_q;
  logic             seen_start_q;
  logic             reg_in_valid;
  logic             txf_in_valid;
  logic             reg_in_ready;
  logic             txf_in_ready;
  logic             dropped_q;
  logic             viol_q;

  // Counters saturate so a long idle never wraps into a false violation
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (v == CNT_MAX) ? v : v + 8'h01;
  endfunction

  assign both_low = !host_select_n && !host_write_strobe_n;
  assign cyc_end  = (state_q == HBW_ACTIVE) && !both_low;
  assign cyc_start = (state_q == HBW_IDLE) && both_low;

  // Strobes are taken as sampled levels, so a pulse shorter than a cycle is missed unless it spans a rising clock edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= HBW_IDLE;
    end else begin
      case (state_q)
        HBW_IDLE: begin
          if (both_low) begin
            state_q <= HBW_ACTIVE;
          end
        end
        HBW_ACTIVE: begin
          if (!both_low) begin
            state_q <= HBW_IDLE;
          end
        end
        default: state_q <= HBW_IDLE;
      endcase
    end
  end

  // Pins are sampled every active cycle, so the value held at the last low cycle is what lands
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fifo_q <= 1'b0;
      addr_q <= 8'h00;
      data_q <= 16'h0000;
    end else if (both_low) begin
      fifo_q <= fifo_select;
      addr_q <= host_addr;
      data_q <= host_data;
    end
  end

  // Routing at cycle end; upper address is not decoded for FIFO writes
  assign txf_in_valid = cyc_end && fifo_q;
  assign reg_in_valid = cyc_end && !fifo_q;

  // Host has no wait pin, so a word arriving at a full buffer is lost and flagged
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dropped_q <= 1'b0;
    end else if ((txf_in_valid && !txf_in_ready) || (reg_in_valid && !reg_in_ready)) begin
      dropped_q <= 1'b1;
    end
  end

  // Monitors of the host's own timing obligations
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      low_cnt_q    <= CNT_ZERO;
      high_cnt_q   <= CNT_MAX;
      start_cnt_q  <= CNT_MAX;
      seen_start_q <= 1'b0;
      viol_q       <= 1'b0;
    end else begin
      low_cnt_q   <= both_low ? sat_inc(low_cnt_q) : CNT_ZERO;
      high_cnt_q  <= both_low ? CNT_ZERO : sat_inc(high_cnt_q);
      start_cnt_q <= cyc_start ? 8'h01 : sat_inc(start_cnt_q);
      // First start after reset has no earlier start to measure from
      if (cyc_start) begin
        seen_start_q <= 1'b1;
        if (seen_start_q && (high_cnt_q < DEASSERT_LIM || start_cnt_q < CYCLE_LIM)) begin
          viol_q <= 1'b1;
        end
      end
      if (cyc_end && low_cnt_q < ASSERT_LIM) begin
        viol_q <= 1'b1;
      end
    end
  end

  assign write_dropped    = dropped_q;
  assign timing_violation = viol_q;

  hbw_skid #(.W($bits(hbw_word_t))) u_reg_buf (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (reg_in_valid),
    .in_ready  (reg_in_ready),
    .in_data   ({addr_q, data_q}),
    .out_valid (reg_wr_valid),
    .out_ready (reg_wr_ready),
    .out_data  (reg_wr_word)
  );

  hbw_skid #(.W(DATA_W)) u_txf_buf (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (txf_in_valid),
    .in_ready  (txf_in_ready),
    .in_data   (data_q),
    .out_valid (txf_wr_valid),
    .out_ready (txf_wr_ready),
    .out_data  (txf_wr_data)
  );

endmodule

// Two-entry FIFO; the entry picked by read pointer rd_q drives the output through a mux
module hbw_skid
  import hbw_pkg::*;
#(
  parameter int unsigned W = DATA_W
)(
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  logic [W-1:0] mem_q [BUF_DEPTH];
  logic         rd_q;
  logic         wr_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;

  // A full buffer refuses even when a pop frees a slot in the same cycle
  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= !wr_q;
      end
      if (pop) begin
        rd_q <= !rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

endmodule

//--- hbw_write_port_asserts.sv
// Checker for the host bus write port
`timescale 1ns/1ps
module hbw_chk
  import hbw_pkg::*;
(
  // Clock, reset and host pins
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              host_select_n,
  input wire logic              host_write_strobe_n,
  input wire logic              fifo_select,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic [DATA_W-1:0] host_data,
  // Streams and status
  input wire logic              reg_wr_valid,
  input wire logic              reg_wr_ready,
  input wire hbw_word_t         reg_wr_word,
  input wire logic              txf_wr_valid,
  input wire logic              txf_wr_ready,
  input wire logic [DATA_W-1:0] txf_wr_data,
  input wire logic              write_dropped,
  input wire logic              timing_violation
);
  logic act_q;
  logic end_q;
  logic fsel_q;
  wire  act   = !host_select_n && !host_write_strobe_n;
  wire  ended = act_q && !act;
  always_ff @(posedge clk) begin
    act_q  <= rst_b && act;
    end_q  <= rst_b && ended;
    fsel_q <= fifo_select;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_reg_push: assert property (ended && !fsel_q |=> reg_wr_valid) else $error("reg word missing");
  chk_txf_push: assert property (ended && fsel_q |=> txf_wr_valid) else $error("tx word missing");
  chk_reg_capture: assert property (ended && !fsel_q && !reg_wr_valid |=>
    reg_wr_word == {$past(host_addr, 2), $past(host_data, 2)}) else $error("reg word wrong");
  chk_txf_capture: assert property (ended && fsel_q && !txf_wr_valid |=>
    txf_wr_data == $past(host_data, 2)) else $error("tx word wrong");
  chk_txf_cause: assert property ($rose(txf_wr_valid) |-> end_q && $past(fsel_q)) else $error("stray tx");
  chk_reg_hold: assert property (reg_wr_valid && !reg_wr_ready |=>
    reg_wr_valid && $stable(reg_wr_word)) else $error("reg word lost");
  chk_txf_hold: assert property (txf_wr_valid && !txf_wr_ready |=>
    txf_wr_valid && $stable(txf_wr_data)) else $error("tx word lost");
  chk_drop_sticky: assert property (write_dropped |=> write_dropped) else $error("drop flag fell");
  cover property (ended && fsel_q);
  cover property (write_dropped);
  cover property (timing_violation);
endmodule
bind hbw_write_port hbw_chk u_chk (.*);

//--- hbw_host_model.sv
// Host bus master model issuing write cycles
`timescale 1ns/1ps
module hbw_host_model
  import hbw_pkg::*;
(
  // Clock in, and bus pins driven by the host
  input wire logic          clk,
  output logic              sel_n = 1'b1,
  output logic              wr_n = 1'b1,
  output logic              fsel = 1'b0,
  output logic [ADDR_W-1:0] addr = 8'h00,
  output logic [DATA_W-1:0] data = 16'h0000
);
  // Released bus shows inverted values so a stale capture cannot pass
  task automatic write(input logic f, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input int lo, input int hi, input logic ord);
    @(negedge clk);
    fsel = f;
    addr = a;
    data = d;
    if (ord) sel_n = 1'b0;
    else wr_n = 1'b0;
    @(negedge clk);
    sel_n = 1'b0;
    wr_n  = 1'b0;
    repeat (lo) @(negedge clk);
    if (ord) wr_n = 1'b1;
    else sel_n = 1'b1;
    @(negedge clk);
    sel_n = 1'b1;
    wr_n  = 1'b1;
    data  = ~d;
    addr  = ~a;
    repeat (hi) @(negedge clk);
  endtask
endmodule

//--- testbench.sv
// Self-checking bench for the host bus write port
`timescale 1ns/1ps
module testbench;
  import hbw_pkg::*;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              sel_n, wr_n, fsel, rvld, tvld, drop, viol;
  logic              rrdy = 1'b0;
  logic              trdy = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data, tdat;
  hbw_word_t         rword;
  hbw_word_t         rq[$];
  logic [DATA_W-1:0] tq[$];
  int                error_cnt = 0;
  int                checked = 0;
  int                seed = 32'h219d60a8;
  bit                stall = 1'b0;
  logic              exp_drop = 1'b0;
  always #2.5 clk = ~clk;
  hbw_host_model u_host (.clk(clk), .sel_n(sel_n), .wr_n(wr_n), .fsel(fsel), .addr(addr), .data(data));
  hbw_write_port uut (.clk(clk), .rst_b(rst_b), .host_select_n(sel_n), .host_write_strobe_n(wr_n),
    .fifo_select(fsel), .host_addr(addr), .host_data(data), .reg_wr_valid(rvld), .reg_wr_ready(rrdy),
    .reg_wr_word(rword), .txf_wr_valid(tvld), .txf_wr_ready(trdy), .txf_wr_data(tdat),
    .write_dropped(drop), .timing_violation(viol));
  task automatic chk_word(input hbw_word_t g, input hbw_word_t e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_data(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t data %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_flag(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic wr(input logic f, input int lo, input int hi);
    hbw_word_t w;
    w = 24'($random(seed));
    if (stall && (f ? tq.size() : rq.size()) == 2) exp_drop = 1'b1;
    else if (f) tq.push_back(w.data);
    else rq.push_back(w);
    u_host.write(f, w.addr, w.data, lo, hi, w.addr[0]);
  endtask
  task automatic drain;
    int n;
    n = 0;
    while (n < 200 && rq.size() + tq.size() != 0) begin
      @(negedge clk);
      n++;
    end
    if (rq.size() + tq.size() != 0) begin
      error_cnt++;
      $display("ERROR %0t words still owed at timeout", $time);
    end
  endtask
  task automatic wrap_up;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(negedge clk) begin
    rrdy <= !stall && 1'($random(seed));
    trdy <= !stall && 1'($random(seed));
  end
  always @(posedge clk) begin
    if (rst_b && rvld && rrdy) chk_word(rword, rq.pop_front());
    if (rst_b && tvld && trdy) chk_data(tdat, tq.pop_front());
  end
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    repeat (40) wr(1'($random(seed)), 7 + ($random(seed) & 3), 23);
    chk_flag(viol, 1'b0);
    stall = 1'b1;
    // Let the ready flops see the stall before the model reads its queues
    @(negedge clk);
    repeat (3) wr(1'b1, 7, 23);
    repeat (3) wr(1'b0, 7, 23);
    chk_flag(drop, exp_drop);
    stall = 1'b0;
    drain;
    wr(1'b0, 3, 23);
    drain;
    chk_flag(viol, 1'b1);
    chk_flag(1'(rq.size() + tq.size() == 0), 1'b1);
    rst_b = 1'b0;
    repeat (4) @(negedge clk);
    chk_flag(viol, 1'b0);
    chk_flag(drop, 1'b0);
    chk_flag(rvld | tvld, 1'b0);
    rst_b = 1'b1;
    wr(1'b1, 7, 0);
    wr(1'b0, 7, 23);
    drain;
    chk_flag(viol, 1'b1);
    chk_flag(1'(rq.size() + tq.size() == 0), 1'b1);
    wrap_up;
  end
endmodule
